// >>> hdl/sleep_sub_swap_params.svh
/*
  Constants of the halt / subtract / nibble exchange executor: opcodes,
  instruction fields, status bit positions, register offsets, reset values.
  Assumes inclusion by bare name from the executor and the assertion checker.
*/
`ifndef SLEEP_SUB_SWAP_PARAMS_SVH
`define SLEEP_SUB_SWAP_PARAMS_SVH

// ----------------------------------------------------------------------
// Instruction encoding
// ----------------------------------------------------------------------
`define OP_HALT        12'h003
`define OP_ARITH_MASK  12'hfc0
`define OP_SUB_VAL     12'h080
`define OP_SWAP_VAL    12'h380
`define OP_DEST_BIT    5
`define OP_FILE_MSB    4

// ----------------------------------------------------------------------
// Status register bit positions
// ----------------------------------------------------------------------
`define ST_CARRY       0
`define ST_HALF_BORROW 1
`define ST_ZERO        2
`define ST_POWERDOWN   3
`define ST_TIMEOUT     4

// ----------------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------------
`define CTL_PRESC_WDT  0
`define CTL_SEL_LSB    1
`define CTL_SEL_MSB    3

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define REG_CONTROL    5'h00
`define REG_STATUS     5'h04
`define REG_ACCUM      5'h08
`define REG_WATCHDOG   5'h0c
`define REG_CORE       5'h10

// ----------------------------------------------------------------------
// Reset values and watchdog constants
// ----------------------------------------------------------------------
`define RST_ACCUM      8'h00
`define RST_STATUS     5'h18
`define RST_CONTROL    4'h0
`define WDT_HALT_LOAD  8'h00
`define WDT_FULL       8'hff

`endif

// >>> hdl/sleep_sub_swap_pkg.sv
/*
  Types of the halt / subtract / nibble exchange executor: core mode,
  file write carrier and the executor's complete state record.
  Assumes the constants header is on the include path.
*/
package sleep_sub_swap_pkg;

  // ----------------------------------------------------------------------
  // Core mode
  // ----------------------------------------------------------------------
  typedef enum logic {
    CORE_RUN,
    CORE_HALTED
  } core_mode_t;

  // ----------------------------------------------------------------------
  // File register write port
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       en;
    logic [4:0] addr;
    logic [7:0] data;
  } file_wr_t;

  // ----------------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic timeout_bit;
    logic powerdown_bit;
    logic zero;
    logic half_borrow_flag;
    logic carry;
  } status_t;

  // ----------------------------------------------------------------------
  // Whole executor state
  // ----------------------------------------------------------------------
  typedef struct packed {
    core_mode_t  mode;
    logic [7:0]  acc;
    status_t     status;
    logic [7:0]  watchdog_counter;
    logic [7:0]  prescaler;
    logic        presc_to_wdt;
    logic [2:0]  presc_sel;
    file_wr_t    fwr;
    logic        halt_pulse;
    logic        ack;
    logic [31:0] rdata;
  } exec_state_t;

endpackage : sleep_sub_swap_pkg

// >>> hdl/sleep_sub_swap_exec.sv
/*
  Executor for three core instructions: halt, subtract accumulator from
  file register, nibble exchange of a file register. Holds accumulator,
  status flags, watchdog counter and prescaler, with an Avalon-MM slave.
  Assumes a fetch unit presenting one word per cycle, a file register
  array with combinational read, and a watchdog tick on mclk.
*/
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/100ps
`include "sleep_sub_swap_params.svh"

module sleep_sub_swap_exec
  import sleep_sub_swap_pkg::*;
#(
  parameter int FILE_COUNT = 32
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // Fetch unit
  input  wire logic        instr_valid,
  input  wire logic [11:0] instr_word,
  output logic             instr_ready,
  // File register array
  output logic [4:0]       file_rd_addr,
  input  wire logic [7:0]  file_rd_data,
  output file_wr_t         file_wr,
  // Watchdog and power control
  input  wire logic        wdt_tick,
  input  wire logic        wake_req,
  output logic             osc_enable,
  output logic             halt_entered,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (FILE_COUNT != 32) begin : g_bad_count
    $error("FILE_COUNT must be 32 for a 5-bit file field");
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  exec_state_t s_q;
  exec_state_t s_d;

  logic        running;
  logic        is_halt;
  logic        is_sub;
  logic        is_swap;
  logic        dest_file;
  logic [8:0]  diff;
  logic [4:0]  half_diff;
  logic [7:0]  sub_res;
  logic [7:0]  swap_res;
  logic [7:0]  sel_mask;
  logic        wdt_step;
  logic        wdt_wrap;
  logic        bus_req;
  logic        bus_take;
  logic        wr_take;
  logic [31:0] wr_merged;
  logic [31:0] rd_word;
  logic [31:0] cur_word;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  assign running   = (s_q.mode == CORE_RUN);
  assign is_halt   = running && instr_valid &&
                     (instr_word == `OP_HALT);
  assign is_sub    = running && instr_valid &&
                     ((instr_word & `OP_ARITH_MASK) == `OP_SUB_VAL);
  assign is_swap   = running && instr_valid &&
                     ((instr_word & `OP_ARITH_MASK) == `OP_SWAP_VAL);
  assign dest_file = instr_word[`OP_DEST_BIT];

  // Address field straight to the array, read in the same cycle
  assign file_rd_addr = instr_word[`OP_FILE_MSB:0];

  // Never stalls while running
  assign instr_ready  = running;

  // ----------------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------------
  // Two's complement file minus accumulator; carry means no borrow
  assign diff      = {1'b0, file_rd_data} - {1'b0, s_q.acc};
  assign half_diff = {1'b0, file_rd_data[3:0]} - {1'b0, s_q.acc[3:0]};
  assign sub_res   = diff[7:0];
  assign swap_res  = {file_rd_data[3:0], file_rd_data[7:4]};

  // ----------------------------------------------------------------------
  // Watchdog stepping
  // ----------------------------------------------------------------------
  // Low presc_sel+1 bits of the prescaler all ones ends a period
  assign sel_mask = 8'((9'h002 << s_q.presc_sel) - 9'h001);
  assign wdt_step = wdt_tick &&
                    (!s_q.presc_to_wdt ||
                     ((s_q.prescaler & sel_mask) == sel_mask));
  assign wdt_wrap = wdt_step && (s_q.watchdog_counter == `WDT_FULL);

  // ----------------------------------------------------------------------
  // Bus slave: one wait cycle, then the answer
  // ----------------------------------------------------------------------
  assign bus_req         = avs_read || avs_write;
  assign bus_take        = bus_req && s_q.ack;
  assign wr_take         = avs_write && s_q.ack;
  assign avs_waitrequest = bus_req && !s_q.ack;
  assign avs_readdata    = s_q.rdata;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (avs_address)
      `REG_CONTROL: begin
        rd_word[`CTL_SEL_MSB:`CTL_SEL_LSB] = s_q.presc_sel;
        rd_word[`CTL_PRESC_WDT]            = s_q.presc_to_wdt;
      end
      `REG_STATUS: begin
        rd_word[4:0] = s_q.status;
      end
      `REG_ACCUM: begin
        rd_word[7:0] = s_q.acc;
      end
      `REG_WATCHDOG: begin
        rd_word[15:0] = {s_q.prescaler, s_q.watchdog_counter};
      end
      `REG_CORE: begin
        rd_word[0] = (s_q.mode == CORE_HALTED);
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // Current contents of the writable register, for byte merging
  always_comb begin
    cur_word = 32'h0000_0000;
    case (avs_address)
      `REG_CONTROL: begin
        cur_word[`CTL_SEL_MSB:`CTL_SEL_LSB] = s_q.presc_sel;
        cur_word[`CTL_PRESC_WDT]            = s_q.presc_to_wdt;
      end
      `REG_STATUS: begin
        cur_word[4:0] = s_q.status;
      end
      `REG_ACCUM: begin
        cur_word[7:0] = s_q.acc;
      end
      default: begin
        cur_word = 32'h0000_0000;
      end
    endcase
  end

  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wr_merged[8*b +: 8] = avs_byteenable[b] ?
                                 avs_writedata[8*b +: 8] :
                                 cur_word[8*b +: 8];
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d            = s_q;
    s_d.fwr.en     = 1'b0;
    s_d.halt_pulse = 1'b0;

    // Bus handshake and read capture
    s_d.ack = bus_req && !s_q.ack;
    if (bus_req && !s_q.ack) begin
      s_d.rdata = rd_word;
    end

    // Software writes first; core events below override them
    if (wr_take) begin
      case (avs_address)
        `REG_CONTROL: begin
          s_d.presc_to_wdt = wr_merged[`CTL_PRESC_WDT];
          s_d.presc_sel    = wr_merged[`CTL_SEL_MSB:`CTL_SEL_LSB];
        end
        `REG_STATUS: begin
          s_d.status = wr_merged[4:0];
        end
        `REG_ACCUM: begin
          s_d.acc = wr_merged[7:0];
        end
        default: begin
          s_d.rdata = s_d.rdata;
        end
      endcase
    end

    // Watchdog counting
    if (wdt_tick && s_q.presc_to_wdt) begin
      s_d.prescaler = s_q.prescaler + 8'h01;
    end
    if (wdt_step) begin
      s_d.watchdog_counter = s_q.watchdog_counter + 8'h01;
    end
    if (wdt_wrap) begin
      s_d.status.timeout_bit = 1'b0;
      s_d.mode               = CORE_RUN;
    end

    // Wake-up from halt
    if (wake_req && (s_q.mode == CORE_HALTED)) begin
      s_d.mode = CORE_RUN;
    end

    // Instruction execution, one cycle each
    case (1'b1)
      is_halt: begin
        s_d.mode                 = CORE_HALTED;
        s_d.halt_pulse           = 1'b1;
        s_d.status.timeout_bit   = 1'b1;
        s_d.status.powerdown_bit = 1'b0;
        s_d.watchdog_counter     = `WDT_HALT_LOAD;
        if (s_q.presc_to_wdt) begin
          s_d.prescaler = 8'h00;
        end
      end
      is_sub: begin
        s_d.status.carry            = !diff[8];
        s_d.status.half_borrow_flag = !half_diff[4];
        s_d.status.zero             = (sub_res == 8'h00);
        if (dest_file) begin
          s_d.fwr.en   = 1'b1;
          s_d.fwr.addr = file_rd_addr;
          s_d.fwr.data = sub_res;
        end else begin
          s_d.acc = sub_res;
        end
      end
      is_swap: begin
        if (dest_file) begin
          s_d.fwr.en   = 1'b1;
          s_d.fwr.addr = file_rd_addr;
          s_d.fwr.data = swap_res;
        end else begin
          s_d.acc = swap_res;
        end
      end
      default: begin
        s_d.fwr.en = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_q                  <= '0;
      s_q.mode             <= CORE_RUN;
      s_q.acc              <= `RST_ACCUM;
      s_q.status           <= `RST_STATUS;
      s_q.presc_to_wdt     <= 1'b0;
      s_q.presc_sel        <= 3'h0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign file_wr      = s_q.fwr;
  assign osc_enable   = (s_q.mode == CORE_RUN);
  assign halt_entered = s_q.halt_pulse;

endmodule : sleep_sub_swap_exec

// >>> testbench/file_array_model.sv
/*
  Behavioural file register array: 32 bytes, combinational read.
  Assumes the executor's registered one-cycle write pulse on mclk.
*/
`timescale 1ns/100ps

module file_array_model
  import sleep_sub_swap_pkg::*;
(
  // Clock
  input  wire logic       mclk,
  // Access
  input  wire logic [4:0] rd_addr,
  output logic [7:0]      rd_data,
  input  wire file_wr_t   wr
);
  logic [7:0] mem [32];

  assign rd_data = mem[rd_addr];

  // Plain clocked process: the bench preloads entries before reset ends
  always @(posedge mclk) begin
    if (wr.en) begin
      mem[wr.addr] <= wr.data;
    end
  end
endmodule : file_array_model

// >>> testbench/sleep_sub_swap_asserts.sv
/*
  Checker for the executor's fetch and file ports.
  Assumes binding into sleep_sub_swap_exec; opcodes from the header.
*/
`timescale 1ns/100ps
`include "sleep_sub_swap_params.svh"

module sleep_sub_swap_asserts
  import sleep_sub_swap_pkg::*;
#(
  parameter int FILE_COUNT = 32
) (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        reset,
  // Watched ports
  input wire logic        instr_valid,
  input wire logic [11:0] instr_word,
  input wire logic        instr_ready,
  input wire logic [4:0]  file_rd_addr,
  input wire logic [7:0]  file_rd_data,
  input wire file_wr_t    file_wr,
  input wire logic        osc_enable,
  input wire logic        halt_entered
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  logic take, is_sub, is_swap;
  assign take    = instr_valid && instr_ready;
  assign is_sub  = (instr_word & `OP_ARITH_MASK) == `OP_SUB_VAL;
  assign is_swap = (instr_word & `OP_ARITH_MASK) == `OP_SWAP_VAL;

  sequence s_halt_take; take && instr_word == `OP_HALT; endsequence
  sequence s_halted; halt_entered && !instr_ready; endsequence
  sequence s_ar_take; take && (is_sub || is_swap); endsequence

  property p_halt; s_halt_take |=> s_halted; endproperty
  property p_osc; s_halt_take |=> !osc_enable; endproperty
  property p_sub_wr;
    take && is_sub && instr_word[5] |=> file_wr.en
      && file_wr.addr == $past(instr_word[4:0]);
  endproperty
  property p_dest_acc; s_ar_take and !instr_word[5] |=> !file_wr.en;
  endproperty
  property p_swap_wr;
    take && is_swap && instr_word[5] |=> file_wr.en
      && file_wr.data == {$past(file_rd_data[3:0]),
                          $past(file_rd_data[7:4])};
  endproperty
  property p_rd_addr; s_ar_take |-> file_rd_addr == instr_word[4:0];
  endproperty
  property p_one_cycle;
    s_ar_take ##1 !instr_valid |=> !file_wr.en;
  endproperty
  property p_halt_wr; s_halt_take |=> !file_wr.en; endproperty

  a_halt: assert property (p_halt) else $error("halt not entered");
  a_osc: assert property (p_osc) else $error("oscillator runs");
  a_sub_wr: assert property (p_sub_wr) else $error("sub write bad");
  a_dest_acc: assert property (p_dest_acc) else $error("file hit");
  a_swap_wr: assert property (p_swap_wr) else $error("swap bad");
  a_rd_addr: assert property (p_rd_addr) else $error("addr bad");
  a_one_cycle: assert property (p_one_cycle) else $error("long wr");
  a_halt_wr: assert property (p_halt_wr) else $error("halt wrote");
endmodule : sleep_sub_swap_asserts

bind sleep_sub_swap_exec sleep_sub_swap_asserts #(
  .FILE_COUNT(FILE_COUNT)
) sleep_sub_swap_asserts_inst (
  .mclk(mclk), .reset(reset), .instr_valid(instr_valid),
  .instr_word(instr_word), .instr_ready(instr_ready),
  .file_rd_addr(file_rd_addr), .file_rd_data(file_rd_data),
  .file_wr(file_wr), .osc_enable(osc_enable),
  .halt_entered(halt_entered)
);

// >>> testbench/tb_top.sv
/*
  Testbench: executes subtract, swap and halt; checks by bus reads, file array peeks and port samples.
  Assumes the design's one-wait-cycle Avalon-MM slave.
*/
`timescale 1ns/100ps

module tb_top;
  import sleep_sub_swap_pkg::*;
  logic        mclk, reset, instr_valid, wdt_tick, wake_req;
  logic        avs_read, avs_write;
  logic [11:0] instr_word;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0]  avs_byteenable;
  logic [4:0]  file_rd_addr;
  logic [7:0]  file_rd_data;
  logic        instr_ready, osc_enable, halt_entered, avs_waitrequest;
  file_wr_t    file_wr;
  int          miscompares, num_checks;

  sleep_sub_swap_exec sleep_sub_swap_exec_inst (
    .mclk(mclk), .reset(reset), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_ready(instr_ready),
    .file_rd_addr(file_rd_addr), .file_rd_data(file_rd_data),
    .file_wr(file_wr), .wdt_tick(wdt_tick), .wake_req(wake_req),
    .osc_enable(osc_enable), .halt_entered(halt_entered),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  file_array_model file_array_model_inst (.mclk(mclk),
    .rd_addr(file_rd_addr), .rd_data(file_rd_data), .wr(file_wr));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  task automatic cmp(input string name, input logic [31:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp

  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] wd, output logic [31:0] d);
    bit done;
    done = 0;
    d = 32'h0000_0000;
    @(posedge mclk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= wd;
    // Request stands until the edge that samples waitrequest low
    for (int i = 0; i < 20 && !done; i++) begin
      @(posedge mclk);
      if (avs_waitrequest === 1'b0) begin
        d = avs_readdata;
        done = 1;
      end
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (!done) begin
      miscompares++;
      close_out();
    end
  endtask : bus

  task automatic rd_cmp(input string n, input logic [4:0] a,
                        input logic [31:0] exp);
    bus(1'b0, a, 32'h0, rd);
    cmp(n, exp, rd);
  endtask : rd_cmp

  task automatic exec(input logic [11:0] w);
    @(posedge mclk);
    instr_valid <= 1'b1;
    instr_word <= w;
    @(posedge mclk);
    instr_valid <= 1'b0;
  endtask : exec

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk);
      wdt_tick <= 1'b1;
      @(posedge mclk);
      wdt_tick <= 1'b0;
    end
  endtask : tick

  initial begin
    {instr_valid, wdt_tick, wake_req, avs_read, avs_write} <= 5'h00;
    {instr_word, avs_address, avs_writedata} <= '0;
    avs_byteenable <= 4'hf;
    reset <= 1'b1;
    file_array_model_inst.mem[3] = 8'h03;
    file_array_model_inst.mem[5] = 8'ha5;
    file_array_model_inst.mem[6] = 8'h3c;
    file_array_model_inst.mem[7] = 8'hb6;
    file_array_model_inst.mem[8] = 8'h10;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    rd_cmp("status", 5'h04, 32'h18);
    rd_cmp("unmapped", 5'h14, 32'h0);
    bus(1'b1, 5'h08, 32'h02, rd);
    exec(12'h0a3);
    rd_cmp("status", 5'h04, 32'h1b);
    cmp("file3", 8'h01, file_array_model_inst.mem[3]);
    $display("test subtract_to_file done");
    exec(12'h385);
    exec(12'h3a6);
    rd_cmp("acc", 5'h08, 32'h5a);
    cmp("file6", 8'hc3, file_array_model_inst.mem[6]);
    rd_cmp("status", 5'h04, 32'h1b);
    $display("test swap done");
    exec(12'h088);
    rd_cmp("acc", 5'h08, 32'hb6);
    rd_cmp("status", 5'h04, 32'h18);
    cmp("file8", 8'h10, file_array_model_inst.mem[8]);
    exec(12'h087);
    exec(12'h0c3);
    rd_cmp("acc", 5'h08, 32'h00);
    avs_byteenable <= 4'he;
    bus(1'b1, 5'h08, 32'hff, rd);
    avs_byteenable <= 4'hf;
    rd_cmp("acc_lane_off", 5'h08, 32'h00);
    rd_cmp("status", 5'h04, 32'h1f);
    $display("test subtract_to_acc done");
    tick(3);
    rd_cmp("watchdog", 5'h0c, 32'h03);
    bus(1'b1, 5'h00, 32'h01, rd);
    tick(1);
    exec(12'h003);
    @(negedge mclk);
    cmp("osc_enable", 1'b0, osc_enable);
    cmp("instr_ready", 1'b0, instr_ready);
    cmp("halt_entered", 1'b1, halt_entered);
    rd_cmp("status", 5'h04, 32'h17);
    rd_cmp("watchdog", 5'h0c, 32'h0);
    rd_cmp("halted", 5'h10, 32'h1);
    exec(12'h0a3);
    repeat (2) @(posedge mclk);
    cmp("file3", 8'h01, file_array_model_inst.mem[3]);
    wake_req <= 1'b1;
    @(posedge mclk);
    wake_req <= 1'b0;
    repeat (2) @(posedge mclk);
    cmp("instr_ready", 1'b1, instr_ready);
    $display("test halt done");
    close_out();
  end

  initial begin
    #200000;
    miscompares++;
    close_out();
  end
endmodule : tb_top
